// *** logic/fmr_pkg.sv ***
// Constants and types of the multi-line flash read path
// How it works
// [R01] Opcode 3Bh takes 3 or 4 address bytes by flag; 3Ch always 4 bytes.
// [R02] Dual read opcode, address, dummy come in on IO0 at rising edges; 8 dummies.
// [R03] Dual read data: two bits per falling edge, upper bit on IO1, next on IO0.
// [R04] Reads start anywhere, address counts up per byte and wraps to zero.
// [R05] Host ends every read only by raising chip select; data streams until then.
// [R06] Read arriving while write in progress is ignored entirely.
// [R07] Opcode 6Bh takes 3 or 4 address bytes by flag; 6Ch always 4 bytes.
// [R08] Host sets the quad enable bit before a quad output read.
// [R09] Quad output read: serial header on IO0, data nibble per falling edge, IO3 first.
// [R10] Quad output read may be clocked up to 166 MHz.
// [R11] Opcode EBh takes 3 or 4 address bytes by flag; ECh always 4 bytes.
// [R12] Host sets the quad enable bit before a quad I/O read.
// [R13] Quad I/O address and dummies on four lines, nibble per rising edge; 6 dummies.
// [R14] Mode byte takes first two clocks after address, counted in dummy total.
// [R15] Upper mode nibble 1010 enters continuous mode: next frame starts at address.
// [R16] Other upper mode nibble leaves continuous mode; next frame needs an opcode.
// [R17] Continuous mode never alters the one-line or four-line command setting.
// [R18] With six dummies, data starts after two mode clocks and four more.
// [R19] Host gives enough dummies; equal to mode clocks means low nibble undriven.
// [R20] Data lines are driven only in the data phase, otherwise left released.
package fmr_pkg;

    // Read opcodes
    localparam logic [7:0] OP_DUAL     = 8'h3b;
    localparam logic [7:0] OP_DUAL_W   = 8'h3c;
    localparam logic [7:0] OP_QUAD     = 8'h6b;
    localparam logic [7:0] OP_QUAD_W   = 8'h6c;
    localparam logic [7:0] OP_QIO      = 8'heb;
    localparam logic [7:0] OP_QIO_W    = 8'hec;

    // Phase lengths in link clocks or bits
    localparam logic [5:0] CMD_BITS         = 6'h08;
    localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
    localparam logic [5:0] ADDR_BITS_WIDE   = 6'h20;
    localparam logic [5:0] MODE_CLOCKS      = 6'h02;
    localparam logic [4:0] DUMMY_OUT_DEF    = 5'h08;
    localparam logic [4:0] DUMMY_QIO_DEF    = 5'h06;
    localparam logic [3:0] MODE_ENTER       = 4'ha;

    // Output enables per read kind
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hf;

    // Sizes and reset values
    localparam int         MEM_ADDR_W_DEF = 24;
    localparam int         FIFO_DEPTH_DEF = 32;
    localparam int         FIFO_WIDTH_DEF = 8;
    localparam logic [5:0] SYNC_RST       = 6'h20;

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} fmr_state_t;
    typedef enum logic [1:0] {KIND_DUAL, KIND_QUAD, KIND_QIO} fmr_kind_t;

endpackage

// *** logic/fmr_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fmr_sync
    import fmr_pkg::*;
#(
    parameter int           W       = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // Pins and synchronised copy
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fmr_sync_regs_t;

    fmr_sync_regs_t q;
    fmr_sync_regs_t d;

    // Second stage reads only the first
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // State registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule

// *** logic/fmr_fifo.sv ***
// Byte FIFO between array fetch and the link shifter
`timescale 1ns/1ps
module fmr_fifo
    import fmr_pkg::*;
#(
    parameter int W = FIFO_WIDTH_DEF,
    parameter int D = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         flush,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [AW:0]         cnt;
        logic [W-1:0]        dout;
    } fmr_fifo_regs_t;

    fmr_fifo_regs_t q;
    fmr_fifo_regs_t d;
    logic           wr_en;
    logic           rd_en;

    assign in_ready  = q.cnt != (AW+1)'(D);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.dout;
    assign wr_en     = in_valid & in_ready;
    assign rd_en     = out_valid & out_ready;

    // Pointers, count and registered head with write bypass
    always_comb begin
        d = q;
        if (wr_en) begin
            d.mem[q.wr] = in_data;
            d.wr        = q.wr + 1'b1;
        end
        if (rd_en) begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt  = q.cnt + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
        d.dout = (wr_en && q.wr == d.rd) ? in_data : q.mem[d.rd];
        if (flush) begin
            d.rd  = '0;
            d.wr  = '0;
            d.cnt = '0;
        end
    end

    // State registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// *** logic/fmr_read_path.sv ***
// Flash read path for dual, quad and quad I/O read commands
`timescale 1ns/1ps
module fmr_read_path
    import fmr_pkg::*;
#(
    parameter int MEM_ADDR_W = MEM_ADDR_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Link pins
    input  wire logic        sck,
    input  wire logic        cs_b,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    // Device settings and status
    input  wire logic        write_in_progress_flag,
    input  wire logic        extended_address_flag,
    input  wire logic        four_line_command_protocol,
    input  wire logic [4:0]  dummy_out_cycles,
    input  wire logic [4:0]  dummy_qio_cycles,
    output logic             continuous_read_mode,
    output logic             read_active,
    output logic             underrun,
    // Array fetch port
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_valid
);

    localparam logic [31:0] ADDR_MASK = 32'((33'h1 << MEM_ADDR_W) - 33'h1);

    typedef struct packed {
        fmr_state_t  st;
        fmr_kind_t   kind;
        logic        wide;
        logic        sck_p;
        logic [7:0]  op;
        logic [31:0] addr;
        logic [5:0]  cnt;
        logic [7:0]  mode;
        logic        cont;
        logic [7:0]  sh;
        logic [3:0]  obits;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
        logic        fetch;
        logic        pend;
        logic        mem_req;
        logic [31:0] mem_addr;
        logic        underrun;
    } fmr_regs_t;

    fmr_regs_t   q;
    fmr_regs_t   d;

    logic        sck_s;
    logic        cs_s;
    logic [3:0]  io_s;
    logic        rise;
    logic        fall;
    logic        qio;
    logic [7:0]  op_n;
    logic [5:0]  op_cnt_n;
    logic [31:0] addr_n;
    logic [5:0]  addr_cnt_n;
    logic [5:0]  abits;
    logic [5:0]  dummy;
    logic [3:0]  dec;
    logic [7:0]  byte_n;
    logic [3:0]  lanes_o;
    logic        push;
    logic        pop;
    logic        f_ready;
    logic        f_valid;
    logic [7:0]  f_data;

    // Returns {valid, wide address, kind}
    function automatic logic [3:0] op_decode(input logic [7:0] op, input logic ext);
        case (op)
            OP_DUAL:   op_decode = {1'b1, ext,  KIND_DUAL};   // [R01]
            OP_DUAL_W: op_decode = {1'b1, 1'b1, KIND_DUAL};   // [R01]
            OP_QUAD:   op_decode = {1'b1, ext,  KIND_QUAD};   // [R07]
            OP_QUAD_W: op_decode = {1'b1, 1'b1, KIND_QUAD};   // [R07]
            OP_QIO:    op_decode = {1'b1, ext,  KIND_QIO};    // [R11]
            OP_QIO_W:  op_decode = {1'b1, 1'b1, KIND_QIO};    // [R11]
            default:   op_decode = 4'h0;
        endcase
    endfunction

    // Pins into the clock domain
    fmr_sync #(
        .W       (6),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .din   ({cs_b, sck, io_in}),
        .dout  ({cs_s, sck_s, io_s})
    );

    // Prefetched read data
    fmr_fifo #(
        .W (8),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .flush     (cs_s),
        .in_valid  (push),
        .in_ready  (f_ready),
        .in_data   (mem_rdata),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data)
    );

    // Link clock edges
    assign rise = sck_s & ~q.sck_p;
    assign fall = ~sck_s & q.sck_p;
    assign qio  = q.kind == KIND_QIO;

    // Opcode shift, one or four lines per clock
    assign op_n     = four_line_command_protocol ? {q.op[3:0], io_s}
                                                 : {q.op[6:0], io_s[0]};
    assign op_cnt_n = q.cnt + (four_line_command_protocol ? 6'h04 : 6'h01);
    assign dec      = op_decode(op_n, extended_address_flag);

    // Address shift, serial or nibble wide
    assign addr_n     = qio ? {q.addr[27:0], io_s} : {q.addr[30:0], io_s[0]};   // [R02] [R13]
    assign addr_cnt_n = q.cnt + (qio ? 6'h04 : 6'h01);
    assign abits      = q.wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;

    // Dummy total, zero selects the default
    always_comb begin
        if (qio) begin
            dummy = {1'b0, (dummy_qio_cycles == 5'h00) ? DUMMY_QIO_DEF
                                                       : dummy_qio_cycles};   // [R13]
        end else begin
            dummy = {1'b0, (dummy_out_cycles == 5'h00) ? DUMMY_OUT_DEF
                                                       : dummy_out_cycles};   // [R02] [R09]
        end
    end

    // Byte being shifted out and bits per falling edge
    assign byte_n  = (q.obits == 4'h0) ? f_data : q.sh;
    assign lanes_o = (q.kind == KIND_DUAL) ? 4'h2 : 4'h4;
    assign pop     = ~cs_s & (q.st == ST_DATA) & fall & (q.obits == 4'h0) & f_valid;
    assign push    = mem_valid & q.pend & q.fetch & ~cs_s;

    // Frame sequencer, shifter and fetch engine
    always_comb begin
        d         = q;
        d.sck_p   = sck_s;
        d.mem_req = 1'b0;
        if (cs_s) begin
            // Deselected: release lines, stop fetch, arm next frame
            d.st       = q.cont ? ST_ADDR : ST_CMD;                 // [R05] [R15]
            d.kind     = q.cont ? KIND_QIO : q.kind;
            d.cnt      = 6'h00;
            d.addr     = 32'h0;
            d.op       = 8'h00;
            d.obits    = 4'h0;
            d.io_oe    = OE_NONE;                                   // [R20]
            d.fetch    = 1'b0;
            d.underrun = 1'b0;
        end else begin
            case (q.st)
                ST_CMD: begin
                    if (rise) begin
                        d.op  = op_n;
                        d.cnt = op_cnt_n;
                        if (op_cnt_n == CMD_BITS) begin
                            d.cnt = 6'h00;
                            if (dec[3]) begin
                                d.wide = dec[2];
                                d.kind = fmr_kind_t'(dec[1:0]);
                                d.st   = ST_ADDR;
                            end else begin
                                d.st   = ST_IGNORE;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        d.addr = addr_n;
                        d.cnt  = addr_cnt_n;
                        if (addr_cnt_n == abits) begin
                            d.cnt = 6'h00;
                            if (write_in_progress_flag) begin
                                d.st = ST_IGNORE;                   // [R06]
                            end else begin
                                d.fetch    = 1'b1;
                                d.mem_addr = addr_n & ADDR_MASK;    // [R04]
                                d.st       = ST_DUMMY;
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        d.cnt = q.cnt + 6'h01;
                        if (qio && q.cnt < MODE_CLOCKS) begin
                            d.mode = {q.mode[3:0], io_s};           // [R14]
                        end
                        if (qio && q.cnt == MODE_CLOCKS - 6'h01) begin
                            // Upper nibble is now in mode[3:0]
                            d.cont = (q.mode[3:0] == MODE_ENTER);   // [R15] [R16] [R17]
                        end
                        if (q.cnt + 6'h01 >= dummy) begin
                            d.st = ST_DATA;                         // [R18]
                        end
                    end
                end
                ST_DATA: begin
                    if (fall) begin
                        if (q.obits == 4'h0 && !f_valid) begin
                            d.underrun = 1'b1;
                        end
                        if (q.kind == KIND_DUAL) begin
                            d.io_out = {2'b00, byte_n[7:6]};        // [R03]
                            d.sh     = {byte_n[5:0], 2'b00};
                            d.io_oe  = OE_DUAL;                     // [R20]
                        end else begin
                            d.io_out = byte_n[7:4];                 // [R09] [R13]
                            d.sh     = {byte_n[3:0], 4'h0};
                            d.io_oe  = OE_QUAD;                     // [R20]
                        end
                        d.obits = ((q.obits == 4'h0) ? 4'h8 : q.obits) - lanes_o;
                    end
                end
                ST_IGNORE: begin
                    d.io_oe = OE_NONE;                              // [R06]
                end
                default: begin
                    d.st = ST_IGNORE;
                end
            endcase
        end
        // Fetch next sequential byte while the FIFO has room
        if (q.pend && mem_valid) begin
            d.pend = 1'b0;
            if (push) begin
                d.mem_addr = (q.mem_addr + 32'h1) & ADDR_MASK;      // [R04]
            end
        end else if (d.fetch && q.fetch && !q.pend && f_ready) begin
            d.mem_req = 1'b1;
            d.pend    = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign io_out               = q.io_out;
    assign io_oe                = q.io_oe;
    assign continuous_read_mode = q.cont;
    assign read_active          = q.fetch;
    assign underrun             = q.underrun;
    assign mem_req              = q.mem_req;
    assign mem_addr             = q.mem_addr;

endmodule

// *** tb/fmr_read_path_monitor.sv ***
// Port checker of the flash read path, bound into its top module
`timescale 1ns/1ps
module fmr_read_path_monitor
    import fmr_pkg::*;
#(
    parameter int MEM_ADDR_W = MEM_ADDR_W_DEF
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // Link pins
    input wire logic        sck,
    input wire logic        cs_b,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe,
    // Settings and status
    input wire logic        write_in_progress_flag,
    input wire logic        extended_address_flag,
    input wire logic        four_line_command_protocol,
    input wire logic [4:0]  dummy_out_cycles,
    input wire logic [4:0]  dummy_qio_cycles,
    input wire logic        continuous_read_mode,
    input wire logic        read_active,
    input wire logic        underrun,
    // Array fetch port
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_valid
);
    localparam logic [31:0] AMASK = (32'h1 << MEM_ADDR_W) - 32'h1;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Lines released once deselect is seen
    property p_oe_idle;
        cs_b [*4] |-> io_oe == OE_NONE;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("lines driven while deselected");

    // Only the dual or quad line sets are ever driven
    property p_oe_code;
        io_oe == OE_NONE || io_oe == OE_DUAL || io_oe == OE_QUAD;
    endproperty
    a_oe_code: assert property (p_oe_code) else $error("odd line set driven");

    // Driving starts only inside an accepted read
    property p_oe_act;
        $rose(|io_oe) |-> read_active;
    endproperty
    a_oe_act: assert property (p_oe_act) else $error("drive outside a read");

    // A busy device never accepts a read
    property p_wip;
        $rose(read_active) |-> !write_in_progress_flag && !$past(write_in_progress_flag);
    endproperty
    a_wip: assert property (p_wip) else $error("read accepted while busy");

    // Deselect ends the read and its fetching
    property p_end;
        cs_b [*4] |-> !read_active && !mem_req;
    endproperty
    a_end: assert property (p_end) else $error("read kept after deselect");

    // Next fetch address is one up, wrapping at the array size
    property p_step;
        mem_valid && read_active ##1 read_active |->
            mem_addr == (($past(mem_addr) + 32'h1) & AMASK);
    endproperty
    a_step: assert property (p_step) else $error("fetch address not incremented");

    // Continuous mode only moves during an accepted read
    property p_cont;
        $changed(continuous_read_mode) |-> read_active;
    endproperty
    a_cont: assert property (p_cont) else $error("mode changed outside a read");

    // No further fetch request in the two clocks after each request
    property p_req;
        mem_req |=> !mem_req [*2];
    endproperty
    a_req: assert property (p_req) else $error("fetches too close");
endmodule

bind fmr_read_path fmr_read_path_monitor #(.MEM_ADDR_W(MEM_ADDR_W)) u_mon (
    .clock, .rst_b, .sck, .cs_b, .io_in, .io_out, .io_oe, .write_in_progress_flag,
    .extended_address_flag, .four_line_command_protocol, .dummy_out_cycles,
    .dummy_qio_cycles, .continuous_read_mode, .read_active, .underrun, .mem_req,
    .mem_addr, .mem_rdata, .mem_valid
);

// *** tb/fmr_host_model.sv ***
// Host controller model that frames reads on the link pins
`timescale 1ns/1ps
module fmr_host_model (
    // Link pins
    output logic            sck,
    output logic            cs_b,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [3:0] hv;
    logic [3:0] he;
    logic [3:0] smp;
    logic       tg;
    logic [7:0] rx [16];

    // Released lines show a changing pattern, never a held level
    assign io_in = (io_oe & io_out) | (~io_oe & he & hv) | (~io_oe & ~he & {tg, ~tg, tg, ~tg});

    // Idle pins, clock standing low
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        hv = 4'h0;
        he = 4'h0;
        tg = 1'b0;
    end

    // One 80 ns link clock: drive while low, sample late while high
    task automatic clk(input logic [3:0] v, input logic [3:0] e);
        hv = v;
        he = e;
        tg = ~tg;
        #40;
        sck = 1'b1; // Quad enable set beforehand, rate far below limit
        #39;
        smp = io_in;
        #1;
        sck = 1'b0;
    endtask

    // Whole read frame: opcode, address, mode, dummies, data bytes
    task automatic frame(input logic [7:0] op, input bit nop, fl, qio, input logic [31:0] a,
                         input int ab, dm, input logic [7:0] md, input int n, w);
        logic [7:0] b;
        b = 8'h00;
        cs_b = 1'b0;
        #40;
        if (!nop && fl) begin
            clk(op[7:4], 4'hf);
            clk(op[3:0], 4'hf);
        end
        for (int i = 0; i < 8 && !nop && !fl; i++) begin
            clk({3'h0, op[7 - i]}, 4'h1);
        end
        for (int i = 0; i < ab * 8; i += (qio ? 4 : 1)) begin
            clk(qio ? a[ab * 8 - 1 - i -: 4] : {3'h0, a[ab * 8 - 1 - i]}, qio ? 4'hf : 4'h1);
        end
        if (qio) begin
            clk(md[7:4], 4'hf);
            clk(md[3:0], (dm > 2) ? 4'hf : 4'h0);
        end
        repeat (qio ? dm - 2 : dm) clk(4'h0, 4'h0);
        for (int k = 0; k < n; k++) begin
            repeat (8 / w) begin
                clk(4'h0, 4'h0);
                b = (w == 2) ? {b[5:0], smp[1:0]} : {b[3:0], smp};
            end
            rx[k] = b;
        end
        cs_b = 1'b1;
        he = 4'h0;
        #400;
    endtask
endmodule

// *** tb/fmr_read_path_tb.sv ***
// Self-checking bench of the flash read path
`timescale 1ns/1ps
module fmr_read_path_tb
    import fmr_pkg::*;
();
    localparam int AW = 24;
    wire        sck;
    wire        cs_b;
    wire  [3:0] io_in;
    logic       clock, rst_b, write_in_progress_flag, extended_address_flag;
    logic       four_line_command_protocol, continuous_read_mode, read_active, underrun;
    logic       mem_req, mem_valid, pend, seen, ur, cm;
    logic [3:0] io_out, io_oe;
    logic [4:0] dummy_out_cycles, dummy_qio_cycles;
    logic [31:0] mem_addr;
    logic [7:0] mem_rdata;
    int         cnt, lat, failures, comparisons;

    fmr_read_path #(.MEM_ADDR_W(AW)) u_dut (
        .clock, .rst_b, .sck, .cs_b, .io_in, .io_out, .io_oe, .write_in_progress_flag,
        .extended_address_flag, .four_line_command_protocol, .dummy_out_cycles,
        .dummy_qio_cycles, .continuous_read_mode, .read_active, .underrun, .mem_req,
        .mem_addr, .mem_rdata, .mem_valid
    );
    fmr_host_model u_host (.sck, .cs_b, .io_in, .io_out, .io_oe);

    // Array contents as a function of the byte address
    function automatic logic [7:0] pat(input logic [31:0] x);
        return x[7:0] + x[23:16] + 8'h5a;
    endfunction

    // Array model answering each fetch after lat clocks
    always begin
        @(posedge clock);
        #1;
        mem_valid = 1'b0;
        if (mem_req === 1'b1) begin
            pend = 1'b1;
            cnt = lat;
        end else if (pend && cnt <= 1) begin
            mem_valid = 1'b1;
            mem_rdata = pat(mem_addr);
            pend = 1'b0;
        end else if (pend) begin
            cnt = cnt - 1;
        end
        seen = seen | (read_active === 1'b1);
        ur = ur | (underrun === 1'b1);
    end

    task automatic check(input bit ok, input string what);
        comparisons++;
        if (!ok) begin
            failures++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // One read with its settings, then data and mode judged
    task automatic chk(input logic [7:0] op, input bit nop, x, fl, qio, input logic [31:0] a,
                       input int ab, dc, input logic [7:0] md, input int n, w, l);
        int   dm;
        dm = (dc != 0) ? dc : (qio ? int'(DUMMY_QIO_DEF) : int'(DUMMY_OUT_DEF));
        // Expected mode follows the upper mode nibble of quad I/O reads only
        if (qio) begin
            cm = (md[7:4] == MODE_ENTER);
        end
        @(posedge clock);
        #1;
        extended_address_flag = x;
        four_line_command_protocol = fl;
        dummy_out_cycles = 5'(dc);
        dummy_qio_cycles = 5'(dc);
        lat = l;
        ur = 1'b0;
        u_host.frame(op, nop, fl, qio, a, ab, dm, md, n, w);
        for (int k = 0; k < n; k++) begin
            check(u_host.rx[k] === pat((a + k) & ((32'h1 << AW) - 1)), "data byte");
        end
        check(ur === 1'b0, "data underrun");
        check(continuous_read_mode === cm, "continuous mode state");
    endtask

    // Busy device: read and mode byte both ignored
    task automatic t_wip;
        @(posedge clock);
        #1;
        write_in_progress_flag = 1'b1;
        seen = 1'b0;
        u_host.frame(OP_QIO, 0, 0, 1, 32'h00000040, 3, 6, 8'ha5, 2, 4);
        check(seen === 1'b0, "read accepted while busy");
        check(continuous_read_mode === 1'b0, "mode taken while busy");
        write_in_progress_flag = 1'b0;
    endtask

    // Every opcode, address width and line width, with default, 4 and 8 dummies
    task automatic t_opcodes;
        chk(OP_DUAL, 0, 0, 0, 0, 32'h00fffffe, 3, 0, 8'h00, 4, 2, 1);
        chk(OP_DUAL, 0, 1, 0, 0, 32'h00123456, 4, 4, 8'h00, 3, 2, 12);
        chk(OP_DUAL_W, 0, 0, 0, 0, 32'h7f000010, 4, 0, 8'h00, 2, 2, 1);
        chk(OP_QUAD, 0, 0, 0, 0, 32'h00000010, 3, 0, 8'h00, 4, 4, 12);
        chk(OP_QUAD, 0, 1, 0, 0, 32'h00334455, 4, 0, 8'h00, 2, 4, 1);
        chk(OP_QUAD_W, 0, 0, 0, 0, 32'h01fffffe, 4, 0, 8'h00, 4, 4, 1);
        chk(OP_QIO, 0, 0, 0, 1, 32'h00abcdef, 3, 0, 8'h00, 3, 4, 1);
        chk(OP_QIO, 0, 1, 0, 1, 32'h00010203, 4, 8, 8'h10, 2, 4, 12);
        chk(OP_QIO_W, 0, 0, 1, 1, 32'h00000100, 4, 0, 8'hff, 3, 4, 1);
    endtask

    // Enter continuous mode, read without opcode, leave it, read with one
    task automatic t_cont;
        chk(OP_QIO, 0, 0, 0, 1, 32'h00000200, 3, 0, 8'ha5, 2, 4, 1);
        chk(8'h00, 1, 0, 0, 1, 32'h00000300, 3, 0, 8'h5a, 2, 4, 1);
        chk(OP_QIO, 0, 0, 0, 1, 32'h00000400, 3, 0, 8'h00, 2, 4, 1);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // 100 MHz system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Reset, then the scenarios in order
    initial begin
        {rst_b, write_in_progress_flag, extended_address_flag} = 3'h0;
        {four_line_command_protocol, mem_valid, pend, seen, ur, cm} = 6'h00;
        dummy_out_cycles = 5'h00;
        dummy_qio_cycles = 5'h00;
        mem_rdata = 8'h00;
        {cnt, lat, failures, comparisons} = {32'd0, 32'd1, 32'd0, 32'd0};
        repeat (20) @(posedge clock);
        #1;
        rst_b = 1'b1;
        repeat (5) @(posedge clock);
        t_wip();
        t_opcodes();
        t_cont();
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        failures++;
        complete_run();
    end
endmodule
